// >>> dtr_pkg.sv
package dtr_pkg;

  // Clock and tone-tick timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int unsigned TICK_HZ = 300_000;
  localparam int unsigned FRAC_GRAIN = 100_000;
  localparam logic [6:0] FRAC_STEP = 7'(TICK_HZ / FRAC_GRAIN);
  localparam logic [6:0] FRAC_MOD = 7'(CLK_HZ / FRAC_GRAIN);

  // Field widths and positions
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned M_W = 6;
  localparam int unsigned N_W = 13;
  localparam int unsigned D_W = 12;
  localparam int unsigned ACC_W = 14;
  localparam int unsigned RUN_BIT = 6;
  localparam int unsigned NUM_CH = 2;

  // Register byte offsets
  localparam logic [7:0] OFF_A_M = 8'h00;
  localparam logic [7:0] OFF_A_N = 8'h04;
  localparam logic [7:0] OFF_A_D = 8'h08;
  localparam logic [7:0] OFF_B_M = 8'h0C;
  localparam logic [7:0] OFF_B_N = 8'h10;
  localparam logic [7:0] OFF_B_D = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // Decoded register index; channel i owns indices 3i..3i+2
  localparam logic [2:0] IDX_STATUS = 3'h6;
  localparam logic [2:0] IDX_NONE = 3'h7;
  localparam int unsigned IDX_PER_CH = 3;

  // Status register bit positions
  localparam int unsigned ST_RUNNING = 0;
  localparam int unsigned ST_PULSE_A = 1;
  localparam int unsigned ST_PULSE_B = 2;
  localparam int unsigned ST_OUT = 3;
  localparam int unsigned ST_HELD = 4;

  // Reset values
  localparam logic [6:0] M_RST = 7'h00;
  localparam logic [12:0] N_RST = 13'h0000;
  localparam logic [11:0] D_RST = 12'h000;

  typedef struct packed {
    logic [6:0] mreg;
    logic [12:0] nreg;
    logic [11:0] dreg;
    logic [13:0] acc;
    logic run_q;
    logic pulse;
  } dtr_chan_t;

  typedef struct packed {
    dtr_chan_t [1:0] ch;
    logic [2:0] rsync;
    logic held;
    logic [6:0] frac;
    logic tick;
    logic running;
    logic [1:0] pdm_err;
    logic ringer;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dtr_state_t;

  // Divisor recovered from the ones-complement encoding of N minus M
  function automatic logic [12:0] dtr_n_eff(input logic [12:0] nreg, input logic [5:0] m);
    dtr_n_eff = 13'(~nreg + {7'h00, m});
  endfunction

endpackage

// >>> dtr_ringer.sv
module dtr_ringer (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic [dtr_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dtr_pkg::DATA_W-1:0] pwdata,
  output logic [dtr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Chip reset pin, asynchronous
  input wire logic chip_reset_output_n,
  // Tone pin
  output logic ringer_out
);
  import dtr_pkg::*;

  dtr_state_t st_r;
  dtr_state_t st_nxt;
  logic rise_w;
  logic run_w;

  function automatic logic [2:0] reg_index(input logic [7:0] a);
    case (a)
      OFF_A_M: reg_index = 3'h0;
      OFF_A_N: reg_index = 3'h1;
      OFF_A_D: reg_index = 3'h2;
      OFF_B_M: reg_index = 3'h3;
      OFF_B_N: reg_index = 3'h4;
      OFF_B_D: reg_index = 3'h5;
      OFF_STATUS: reg_index = IDX_STATUS;
      default: reg_index = IDX_NONE;
    endcase
  endfunction

  always_comb
  begin
    logic [2:0] idx;
    logic [6:0] frac_sum;
    logic [13:0] step;
    logic [12:0] neff;
    logic [2:0] pdm_sum;
    logic [31:0] rdata;
    logic wr_go;
    idx = reg_index(paddr);
    frac_sum = 7'h00;
    step = 14'h0000;
    neff = 13'h0000;
    pdm_sum = 3'h0;
    rdata = 32'h0000_0000;
    wr_go = 1'b0;
    st_nxt = st_r;

    // Three-stage pin sync; the level is taken only once stages two and three agree
    st_nxt.rsync = {st_r.rsync[1:0], chip_reset_output_n};
    if (st_r.rsync[1] == st_r.rsync[2])
    begin
      st_nxt.held = ~st_r.rsync[2];
    end

    // Fractional divider: 3 ticks per 100 clocks keeps the tick rate exact on average
    frac_sum = 7'(st_r.frac + FRAC_STEP);
    st_nxt.tick = (frac_sum >= FRAC_MOD);
    st_nxt.frac = st_nxt.tick ? 7'(frac_sum - FRAC_MOD) : frac_sum;

    // Edge detect on the run bits, and the shared run condition
    rise_w = 1'b0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      st_nxt.ch[i].run_q = st_r.ch[i].mreg[RUN_BIT];
      if (st_r.ch[i].mreg[RUN_BIT] && !st_r.ch[i].run_q)
      begin
        rise_w = 1'b1;
      end
    end
    run_w = st_r.ch[0].mreg[RUN_BIT] && st_r.ch[1].mreg[RUN_BIT] && !st_r.held;
    st_nxt.running = run_w;

    // Both counters share one restart so identical settings stay in phase
    for (int i = 0; i < NUM_CH; i++)
    begin
      neff = dtr_n_eff(st_r.ch[i].nreg, st_r.ch[i].mreg[M_W-1:0]);
      step = 14'(st_r.ch[i].acc + {8'h00, st_r.ch[i].mreg[M_W-1:0]});
      if (step >= {1'b0, neff})
      begin
        step = 14'(step - {1'b0, neff});
      end
      if (rise_w || st_r.held)
      begin
        st_nxt.ch[i].acc = 14'h0000;
      end
      else if (run_w && st_r.tick)
      begin
        st_nxt.ch[i].acc = step;
      end
      st_nxt.ch[i].pulse = run_w && (st_r.ch[i].acc < {2'b00, st_r.ch[i].dreg});
    end

    // First-order pulse-density sum of the two pulse trains
    pdm_sum = 3'({1'b0, st_r.pdm_err} + {2'b00, st_r.ch[0].pulse} + {2'b00, st_r.ch[1].pulse});
    if (!run_w)
    begin
      st_nxt.pdm_err = 2'h0;
      st_nxt.ringer = 1'b0;
    end
    else if (pdm_sum >= 3'h2)
    begin
      st_nxt.pdm_err = 2'(pdm_sum - 3'h2);
      st_nxt.ringer = 1'b1;
    end
    else
    begin
      st_nxt.pdm_err = pdm_sum[1:0];
      st_nxt.ringer = 1'b0;
    end

    // APB: one wait state, write commits at the edge where pready is seen high
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (idx == 3'(IDX_PER_CH * i))
      begin
        rdata = {25'h000_0000, st_r.ch[i].mreg};
      end
      else if (idx == 3'(IDX_PER_CH * i + 1))
      begin
        rdata = {19'h0_0000, st_r.ch[i].nreg};
      end
      else if (idx == 3'(IDX_PER_CH * i + 2))
      begin
        rdata = {20'h0_0000, st_r.ch[i].dreg};
      end
    end
    if (idx == IDX_STATUS)
    begin
      rdata[ST_RUNNING] = st_r.running;
      rdata[ST_PULSE_A] = st_r.ch[0].pulse;
      rdata[ST_PULSE_B] = st_r.ch[1].pulse;
      rdata[ST_OUT] = st_r.ringer;
      rdata[ST_HELD] = st_r.held;
    end
    st_nxt.pready = psel && penable && !st_r.pready;
    st_nxt.pslverr = 1'b0;
    if (st_nxt.pready)
    begin
      st_nxt.pslverr = (idx == IDX_NONE);
      st_nxt.prdata = pwrite ? 32'h0000_0000 : rdata;
    end
    wr_go = psel && penable && pwrite && st_r.pready;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (wr_go && idx == 3'(IDX_PER_CH * i))
      begin
        st_nxt.ch[i].mreg = pwdata[6:0];
      end
      if (wr_go && idx == 3'(IDX_PER_CH * i + 1))
      begin
        st_nxt.ch[i].nreg = pwdata[N_W-1:0];
      end
      if (wr_go && idx == 3'(IDX_PER_CH * i + 2))
      begin
        st_nxt.ch[i].dreg = pwdata[D_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        st_r.ch[i].mreg <= M_RST;
        st_r.ch[i].nreg <= N_RST;
        st_r.ch[i].dreg <= D_RST;
        st_r.ch[i].acc <= 14'h0000;
        st_r.ch[i].run_q <= 1'b0;
        st_r.ch[i].pulse <= 1'b0;
      end
      // Held off until the pin has been seen released
      st_r.rsync <= 3'h0;
      st_r.held <= 1'b1;
      st_r.frac <= 7'h00;
      st_r.tick <= 1'b0;
      st_r.running <= 1'b0;
      st_r.pdm_err <= 2'h0;
      st_r.ringer <= 1'b0;
      st_r.pready <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.prdata <= 32'h0000_0000;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign ringer_out = st_r.ringer;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_run_rise;
    rise_w;
  endsequence

  sequence s_both_pulse;
    (st_r.ch[0].pulse && st_r.ch[1].pulse && run_w) [*2];
  endsequence

  property p_tick_rate;
    st_r.tick |-> ##[33:34] st_r.tick;
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("tone tick spacing wrong");

  property p_tick_gap;
    st_r.tick |=> !st_r.tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tone tick too soon");

  property p_reset_silent;
    st_r.held |=> !st_r.ringer;
  endproperty
  a_reset_silent: assert property (p_reset_silent) else $error("tone during chip reset");

  // Counters pinned at zero so the tone restarts in phase once the pin is released
  property p_held_clear;
    st_r.held |=> (st_r.ch[0].acc == 14'h0000) && (st_r.ch[1].acc == 14'h0000);
  endproperty
  a_held_clear: assert property (p_held_clear) else $error("counter moved during chip reset");

  property p_run_sync;
    s_run_rise |=> (st_r.ch[0].acc == 14'h0000) && (st_r.ch[1].acc == 14'h0000);
  endproperty
  a_run_sync: assert property (p_run_sync) else $error("counters not restarted together");

  property p_edge_only;
    (st_r.ch[0].mreg[RUN_BIT] && st_r.ch[1].mreg[RUN_BIT]) [*2] |-> !rise_w;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("restart without rising run bit");

  property p_stop;
    !run_w && !rise_w && !st_r.held |=> $stable(st_r.ch[0].acc) && $stable(st_r.ch[1].acc);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped");

  property p_duty;
    run_w && (st_r.ch[0].acc < {2'b00, st_r.ch[0].dreg}) |=> st_r.ch[0].pulse;
  endproperty
  a_duty: assert property (p_duty) else $error("pulse low inside duty window");

  property p_duty_b;
    run_w && (st_r.ch[1].acc < {2'b00, st_r.ch[1].dreg}) |=> st_r.ch[1].pulse;
  endproperty
  a_duty_b: assert property (p_duty_b) else $error("pulse B low inside duty window");

  property p_sum;
    s_both_pulse |=> st_r.ringer;
  endproperty
  a_sum: assert property (p_sum) else $error("sum low with both pulses high");

  property p_off_low;
    !run_w [*2] |=> !st_r.ringer;
  endproperty
  a_off_low: assert property (p_off_low) else $error("ringer high while stopped");

  property p_m_write;
    psel && penable && pwrite && st_r.pready && (paddr == OFF_A_M)
      |=> st_r.ch[0].mreg == 7'($past(pwdata));
  endproperty
  a_m_write: assert property (p_m_write) else $error("M register write lost");

  property p_apb_wait;
    psel && penable && !st_r.pready |=> st_r.pready ##1 !st_r.pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("APB answer timing wrong");

  // Unmapped offsets still answer on time, so a stray access never stalls the bus
  property p_bad_addr;
    psel && penable && !st_r.pready && (reg_index(paddr) == IDX_NONE) |=> st_r.pready && st_r.pslverr;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("unmapped access not flagged");

endmodule // dtr_ringer

// >>> dtr_booster_model.sv
module dtr_booster_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pulse stream from the tone pin
  input wire logic ringer_out,
  // Measurement window
  input wire logic clr,
  output logic [31:0] hi_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // The booster only low-pass filters the pin, so high time is what the transducer hears
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      hi_cnt <= 32'h0000_0000;
    else if (clr)
      hi_cnt <= 32'h0000_0000;
    else if (ringer_out)
      hi_cnt <= hi_cnt + 32'h0000_0001;
  end
endmodule // dtr_booster_model

// >>> dtr_ringer_tb_top.sv
module dtr_ringer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dtr_pkg::*;
  logic clk, resetn, psel, penable, pwrite, chip_reset_output_n, pready, pslverr, ringer_out, clr, errv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv, hi_cnt;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  dtr_ringer dut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_reset_output_n(chip_reset_output_n), .ringer_out(ringer_out));
  dtr_booster_model load (.clk(clk), .resetn(resetn), .ringer_out(ringer_out), .clr(clr), .hi_cnt(hi_cnt));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One transfer; an idle edge follows so back-to-back calls never drive psel twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    chk({31'h0, pready}, 32'h0000_0001);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic prog(input logic [31:0] ma, input logic [31:0] mb, input logic [31:0] n,
    input logic [31:0] da, input logic [31:0] db);
    int t0;
    apb(1'b1, OFF_A_M, ma & 32'h0000_003F);
    apb(1'b1, OFF_B_M, mb & 32'h0000_003F);
    t0 = cyc;
    apb(1'b1, OFF_A_N, n);
    apb(1'b1, OFF_A_D, da);
    apb(1'b1, OFF_B_N, n);
    apb(1'b1, OFF_B_D, db);
    while (cyc - t0 < 10050) @(posedge clk);
    apb(1'b1, OFF_A_M, ma);
    apb(1'b1, OFF_B_M, mb);
  endtask
  task automatic t_regs();
    logic [31:0] msk [6] = '{32'h0000_007F, 32'h0000_1FFF, 32'h0000_0FFF, 32'h0000_007F, 32'h0000_1FFF, 32'h0000_0FFF};
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000);
      chk(rdv, 32'h0000_0000);
    end
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk({31'h0, errv}, 32'h0000_0001);
    chk(rdv, 32'h0000_0000);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, 8'(4 * i), 32'hFFFF_FFFF);
      apb(1'b0, 8'(4 * i), 32'h0000_0000);
      chk(rdv, msk[i]);
    end
    for (int i = 0; i < 6; i++) apb(1'b1, 8'(4 * i), 32'h0000_0000);
    $display("Test registers done");
  endtask
  // M=1, N=8 gives 37.5 kHz, a period of 266.7 clocks; B is silent with D=0
  task automatic t_freq();
    int start, rises, e;
    logic prev;
    prog(32'h0000_0041, 32'h0000_0041, 32'h0000_1FF8, 32'h0000_0004, 32'h0000_0000);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk({31'h0, rdv[ST_RUNNING]}, 32'h0000_0001);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    start = cyc;
    rises = 0;
    prev = 1'b1;
    while (cyc - start < 8000)
    begin
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      if (rdv[ST_PULSE_A] && !prev) rises++;
      prev = rdv[ST_PULSE_A];
    end
    e = cyc - start;
    chk({31'h0, rises >= 28 && rises <= 31}, 32'h0000_0001);
    chk({31'h0, hi_cnt * 100 >= e * 23 && hi_cnt * 100 <= e * 27}, 32'h0000_0001);
    $display("Test frequency done");
  endtask
  task automatic t_sync();
    prog(32'h0000_0051, 32'h0000_0051, 32'h0000_037B, 32'h0000_0E4A, 32'h0000_0E4A);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk({31'h0, rdv[ST_PULSE_A]}, 32'h0000_0001);
    for (int i = 0; i < 300; i++)
    begin
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      chk({31'h0, rdv[ST_PULSE_A]}, {31'h0, rdv[ST_PULSE_B]});
      chk({31'h0, rdv[ST_OUT]}, 32'h0000_0001);
    end
    $display("Test sync done");
  endtask
  task automatic t_chip();
    chip_reset_output_n <= 1'b0;
    repeat (10) @(posedge clk);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk({31'h0, rdv[ST_HELD]}, 32'h0000_0001);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (300) @(posedge clk);
    chk(hi_cnt, 32'h0000_0000);
    chip_reset_output_n <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk({31'h0, rdv[ST_HELD]}, 32'h0000_0000);
    $display("Test chip reset done");
  endtask
  task automatic t_stop();
    apb(1'b1, OFF_A_M, 32'h0000_0011);
    repeat (5) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (300) @(posedge clk);
    chk(hi_cnt, 32'h0000_0000);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk({31'h0, rdv[ST_RUNNING]}, 32'h0000_0000);
    $display("Test stop done");
  endtask
  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    chip_reset_output_n = 1'b1;
    clr = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    t_regs();
    t_freq();
    t_sync();
    t_chip();
    t_stop();
    stop_test();
  end
  // About 30000 cycles expected; twice that means a hang
  initial
  begin
    #(60000 * 100);
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule // dtr_ringer_tb_top
